// >>> can_status_wakeup_flags.sv
// Flag, bus-state and interrupt logic of a CAN receiver flag register
//
// Behaviour
// - Set wake-up flag bit 7 on bus activity in sleep when wake-up enabled.
// - Wake-up interrupt pending while wake-up flag set and unmasked.
// - Set status-change flag bit 6 when counters change the bus state.
// - Error interrupt pending while status-change flag set and unmasked.
// - State fields update only while no status-change flag is pending.
// - Receiver state in bits 5-4; 00 means receive error count below 96.
// - Transmitter state in bits 3-2; 00 means transmit error count below 96.
// - State fields are not affected by initialization mode.
// - On status-change, fields show the state matching the causing counters, unless it lands on the write that clears a pending flag.
// - Writing one clears a flag, zero is ignored; state fields read-only.
// - Flags held in reset while init request and acknowledge are both one.
// - Software flag writes act only outside initialization mode.
module can_status_wakeup_flags (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Controller side
    input  wire logic        busActivity,
    input  wire logic        initModeAcknowledge,
    input  wire logic [8:0]  transmitErrorCount,
    input  wire logic [7:0]  receiveErrorCount,
    // Requests
    output logic             initModeRequest,
    output logic             sleepRequest,
    output logic             wakeUpIrq,
    output logic             errorIrq,
    output logic             irq
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Bus activity comes from the transceiver pin, so it is retimed first
    logic activityMeta_q;
    logic activitySync_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            activityMeta_q <= 1'b0;
            activitySync_q <= 1'b0;
        end else begin
            activityMeta_q <= busActivity;
            activitySync_q <= activityMeta_q;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic                      wakeFlag_q;
    logic                      changeFlag_q;
    can_flag_pkg::bus_status_t status_q;
    can_flag_pkg::bus_status_t liveStatus;
    can_flag_pkg::bus_status_t seenStatus_q;
    logic [7:0]                intEnable_q;
    logic [2:0]                control_q;
    logic                      initActive;
    logic                      wakeEnable;
    logic                      sleepMode;

    assign initActive = control_q[can_flag_pkg::CTL_INIT_REQ] & initModeAcknowledge;
    assign wakeEnable = control_q[can_flag_pkg::CTL_WAKE_EN];
    assign sleepMode  = control_q[can_flag_pkg::CTL_SLEEP];

    // ------------------------------------------------------------
    // Bus state decode
    // ------------------------------------------------------------
    always_comb begin
        if ({1'b0, receiveErrorCount} > can_flag_pkg::PASSIVE_LEVEL) begin
            liveStatus.rx = can_flag_pkg::STATE_PASSIVE;
        end else if ({1'b0, receiveErrorCount} >= can_flag_pkg::WARN_LEVEL) begin
            liveStatus.rx = can_flag_pkg::STATE_WARNING;
        end else begin
            liveStatus.rx = can_flag_pkg::STATE_OK;
        end
        if (transmitErrorCount > can_flag_pkg::BUSOFF_LEVEL) begin
            liveStatus.tx = can_flag_pkg::STATE_BUSOFF;
        end else if (transmitErrorCount > can_flag_pkg::PASSIVE_LEVEL) begin
            liveStatus.tx = can_flag_pkg::STATE_PASSIVE;
        end else if (transmitErrorCount >= can_flag_pkg::WARN_LEVEL) begin
            liveStatus.tx = can_flag_pkg::STATE_WARNING;
        end else begin
            liveStatus.tx = can_flag_pkg::STATE_OK;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic        awHeld_q;
    logic        wHeld_q;
    logic [3:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        doWrite;

    assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= 4'h0;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            // Held off while a response waits, so only one write is ever in flight
            s_axi_awready <= ~awHeld_q & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~wHeld_q & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awAddr_q)
                    can_flag_pkg::OFF_FLAG_STATUS,
                    can_flag_pkg::OFF_INT_ENABLE,
                    can_flag_pkg::OFF_CONTROL,
                    can_flag_pkg::OFF_COUNTERS: s_axi_bresp <= can_flag_pkg::RESP_OKAY;
                    default:                    s_axi_bresp <= can_flag_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write-one-to-clear strobes; blocked during initialization mode
    logic flagWrite;
    logic clearWake;
    logic clearChange;

    assign flagWrite   = doWrite & (awAddr_q == can_flag_pkg::OFF_FLAG_STATUS)
                         & wStrb_q[0] & ~initActive;
    assign clearWake   = flagWrite & wData_q[can_flag_pkg::WAKE_BIT];
    assign clearChange = flagWrite & wData_q[can_flag_pkg::CHANGE_BIT];

    // ------------------------------------------------------------
    // Control and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            intEnable_q <= can_flag_pkg::ENABLE_RESET;
            control_q   <= can_flag_pkg::CTL_RESET;
        end else if (doWrite & wStrb_q[0]) begin
            if (awAddr_q == can_flag_pkg::OFF_INT_ENABLE) begin
                intEnable_q <= wData_q[7:0];
            end
            if (awAddr_q == can_flag_pkg::OFF_CONTROL) begin
                control_q <= wData_q[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    // Set beats clear so an event landing on the clearing write is kept
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wakeFlag_q <= 1'b0;
        end else if (initActive) begin
            wakeFlag_q <= 1'b0;
        end else if (activitySync_q & sleepMode & wakeEnable) begin
            wakeFlag_q <= 1'b1;
        end else if (clearWake) begin
            wakeFlag_q <= 1'b0;
        end
    end

    logic stateMoved;
    assign stateMoved = (liveStatus != seenStatus_q);

    // Tracks the last decoded state so only a real transition raises the flag
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seenStatus_q <= '{can_flag_pkg::STATE_OK, can_flag_pkg::STATE_OK};
        end else begin
            seenStatus_q <= liveStatus;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            changeFlag_q <= 1'b0;
        end else if (initActive) begin
            changeFlag_q <= 1'b0;
        end else if (stateMoved) begin
            changeFlag_q <= 1'b1;
        end else if (clearChange) begin
            changeFlag_q <= 1'b0;
        end
    end

    // Frozen while the flag stands; a change during the freeze raises no new flag,
    // as seenStatus follows every cycle; the fields take the live state once cleared.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= '{can_flag_pkg::STATE_OK, can_flag_pkg::STATE_OK};
        end else if (~changeFlag_q) begin
            status_q <= liveStatus;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wakeUpIrq       <= 1'b0;
            errorIrq        <= 1'b0;
            irq             <= 1'b0;
            initModeRequest <= 1'b0;
            sleepRequest    <= 1'b0;
        end else begin
            wakeUpIrq       <= wakeFlag_q & intEnable_q[can_flag_pkg::WAKE_BIT];
            errorIrq        <= changeFlag_q & intEnable_q[can_flag_pkg::CHANGE_BIT];
            irq             <= (wakeFlag_q & intEnable_q[can_flag_pkg::WAKE_BIT])
                               | (changeFlag_q & intEnable_q[can_flag_pkg::CHANGE_BIT]);
            initModeRequest <= control_q[can_flag_pkg::CTL_INIT_REQ];
            sleepRequest    <= sleepMode;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [31:0] readWord;

    always_comb begin
        readWord = 32'h0000_0000;
        unique case (s_axi_araddr)
            can_flag_pkg::OFF_FLAG_STATUS: readWord[7:0] = {wakeFlag_q, changeFlag_q,
                                                           status_q, 2'h0};
            can_flag_pkg::OFF_INT_ENABLE:  readWord[7:0] = intEnable_q;
            can_flag_pkg::OFF_CONTROL:     readWord[3:0] = {initModeAcknowledge, control_q};
            can_flag_pkg::OFF_COUNTERS:    readWord[24:0] = {receiveErrorCount, 7'h00,
                                                            transmitErrorCount, 1'b0};
            default:                       readWord = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= readWord;
                unique case (s_axi_araddr)
                    can_flag_pkg::OFF_FLAG_STATUS,
                    can_flag_pkg::OFF_INT_ENABLE,
                    can_flag_pkg::OFF_CONTROL,
                    can_flag_pkg::OFF_COUNTERS: s_axi_rresp <= can_flag_pkg::RESP_OKAY;
                    default:                    s_axi_rresp <= can_flag_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // can_status_wakeup_flags

// >>> can_flag_pkg.sv
// Package: register map, field layout and thresholds of the CAN flag block
package can_flag_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_FLAG_STATUS = 4'h0;
    localparam logic [3:0] OFF_INT_ENABLE  = 4'h4;
    localparam logic [3:0] OFF_CONTROL     = 4'h8;
    localparam logic [3:0] OFF_COUNTERS    = 4'hc;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WAKE_BIT      = 7;
    localparam int CHANGE_BIT    = 6;
    localparam int RX_STATE_LSB  = 4;
    localparam int TX_STATE_LSB  = 2;
    localparam int CTL_WAKE_EN   = 0;
    localparam int CTL_INIT_REQ  = 1;
    localparam int CTL_SLEEP     = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FLAG_RESET  = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [2:0] CTL_RESET   = 3'h0;

    // ------------------------------------------------------------
    // Error count thresholds
    // ------------------------------------------------------------
    localparam logic [8:0] WARN_LEVEL    = 9'h060;
    localparam logic [8:0] PASSIVE_LEVEL = 9'h07f;
    localparam logic [8:0] BUSOFF_LEVEL  = 9'h0ff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STATE_OK      = 2'h0,
        STATE_WARNING = 2'h1,
        STATE_PASSIVE = 2'h2,
        STATE_BUSOFF  = 2'h3
    } bus_state_t;

    typedef struct packed {
        bus_state_t rx;
        bus_state_t tx;
    } bus_status_t;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_t;

endpackage

// >>> can_status_wakeup_flags_checker.sv
// Concurrent checks on the ports of the CAN flag and status block
module can_status_wakeup_flags_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Controller side and requests
    input wire logic        initModeRequest,
    input wire logic        initModeAcknowledge,
    input wire logic        wakeUpIrq,
    input wire logic        errorIrq,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    irq_merge_a: assert property (irq == (wakeUpIrq | errorIrq))
        else $error("merged request differs from its sources");
    init_quiet_a: assert property (initModeAcknowledge ##1 initModeRequest
        |-> ##1 !wakeUpIrq && !errorIrq) else $error("request pending in init mode");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule // can_status_wakeup_flags_checker

bind can_status_wakeup_flags can_status_wakeup_flags_checker checker_i (.*);

// >>> can_bus_model.sv
// Behavioural model of the controller and bus side of the flag block
module can_bus_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // From the block and the bench
    input  wire logic       initModeRequest,
    input  wire logic       activityCmd,
    input  wire logic [8:0] tecCmd,
    input  wire logic [7:0] recCmd,
    // Towards the block
    output logic            busActivity,
    output logic            initModeAcknowledge,
    output logic [8:0]      transmitErrorCount,
    output logic [7:0]      receiveErrorCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ackPipe_q;

    // Acknowledge trails the request by two cycles, as a slow controller would
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ackPipe_q          <= 2'h0;
            transmitErrorCount <= 9'h000;
            receiveErrorCount  <= 8'h00;
        end else begin
            ackPipe_q          <= {ackPipe_q[0], initModeRequest};
            transmitErrorCount <= tecCmd;
            receiveErrorCount  <= recCmd;
        end
    end
    assign initModeAcknowledge = ackPipe_q[1];
    assign busActivity         = activityCmd;
endmodule // can_bus_model

// >>> tb.sv
// Self-checking testbench of the CAN flag and status block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, reset_n = 1'b0, activityCmd = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [8:0]  tecCmd = 9'h000, transmitErrorCount;
    logic [7:0]  recCmd = 8'h00, receiveErrorCount;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        busActivity, initModeAcknowledge, initModeRequest, sleepRequest;
    logic        wakeUpIrq, errorIrq, irq;
    int          n_errors = 0, n_tests = 0;

    can_status_wakeup_flags dut (.*);
    can_bus_model partner (.*);
    always #20 mclk = ~mclk;

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic awDone, wDone;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        awDone = 1'b0;
        wDone = 1'b0;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1 && !awDone) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !wDone) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Ready comes late on purpose, so the slave must hold its answer
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        @(posedge mclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge mclk);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(rd, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h0);
        rchk(can_flag_pkg::OFF_INT_ENABLE, 32'h0);
        rchk(can_flag_pkg::OFF_CONTROL, 32'h0);
        rchk(can_flag_pkg::OFF_COUNTERS, 32'h0);
    endtask
    task automatic t_unmapped();
        rchk(4'h2, 32'h0);
        chk(resp, can_flag_pkg::RESP_SLVERR);
        wr(4'h2, 32'hff);
        chk(resp, can_flag_pkg::RESP_SLVERR);
    endtask
    task automatic t_wake();
        wr(can_flag_pkg::OFF_CONTROL, 32'h4);
        activityCmd <= 1'b1;
        cyc(8);
        activityCmd <= 1'b0;
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h0);
        wr(can_flag_pkg::OFF_INT_ENABLE, 32'h80);
        wr(can_flag_pkg::OFF_CONTROL, 32'h5);
        chk(sleepRequest, 1'b1);
        activityCmd <= 1'b1;
        cyc(8);
        activityCmd <= 1'b0;
        chk({wakeUpIrq, irq}, 2'h3);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h80);
        wr(can_flag_pkg::OFF_INT_ENABLE, 32'h0);
        cyc(3);
        chk({wakeUpIrq, irq}, 2'h0);
        wr(can_flag_pkg::OFF_FLAG_STATUS, 32'h80);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h0);
        wr(can_flag_pkg::OFF_CONTROL, 32'h0);
        chk(sleepRequest, 1'b0);
    endtask
    task automatic t_status();
        wr(can_flag_pkg::OFF_INT_ENABLE, 32'h40);
        tecCmd <= 9'd96;
        cyc(4);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h44);
        chk(errorIrq, 1'b1);
        tecCmd <= 9'd128;
        cyc(4);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h44);
        wr(can_flag_pkg::OFF_FLAG_STATUS, 32'h3c);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h44);
        wr(can_flag_pkg::OFF_FLAG_STATUS, 32'h40);
        cyc(2);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h08);
        chk(errorIrq, 1'b0);
        recCmd <= 8'd96;
        cyc(4);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h58);
        rchk(can_flag_pkg::OFF_COUNTERS, 32'h00c00100);
        wr(can_flag_pkg::OFF_FLAG_STATUS, 32'h40);
        tecCmd <= 9'd256;
        cyc(4);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h5c);
        wr(can_flag_pkg::OFF_FLAG_STATUS, 32'h40);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h1c);
    endtask
    task automatic t_init();
        tecCmd <= 9'd0;
        cyc(4);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h50);
        wr(can_flag_pkg::OFF_CONTROL, 32'h2);
        cyc(5);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h10);
        chk({initModeRequest, errorIrq}, 2'h2);
        rchk(can_flag_pkg::OFF_CONTROL, 32'h0a);
        wr(can_flag_pkg::OFF_FLAG_STATUS, 32'h40);
        chk(resp, can_flag_pkg::RESP_OKAY);
        wr(can_flag_pkg::OFF_CONTROL, 32'h0);
        cyc(5);
        recCmd <= 8'd0;
        cyc(4);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h40);
        wr(can_flag_pkg::OFF_FLAG_STATUS, 32'h40);
        rchk(can_flag_pkg::OFF_FLAG_STATUS, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_unmapped();
        t_wake();
        t_status();
        t_init();
        tally_and_finish();
    end
    // The scenarios take well under a thousand cycles; a hang stops here
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
endmodule // tb
